// [inc/cms_pkg.sv]
// Package of settings constants for the clock manager settings block.
package cms_pkg;
  localparam logic [31:0] CMS_CTRL_OFF = 32'h0000_0000;
  localparam logic [31:0] CMS_PHASE_OFF = 32'h0000_0004;
  localparam logic [31:0] CMS_RATIO_OFF = 32'h0000_0008;
  localparam logic [31:0] CMS_JF_OFF = 32'h0000_000c;
  localparam logic [31:0] CMS_PERIOD_OFF = 32'h0000_0010;
  localparam logic [31:0] CMS_STATUS_OFF = 32'h0000_0014;
  localparam logic [31:0] CMS_PSTEP_OFF = 32'h0000_0018;
  // Control field positions.
  localparam int CMS_CTRL_OPT_BIT = 0;
  localparam int CMS_CTRL_MODE_LSB = 1;
  localparam int CMS_CTRL_HOLD_BIT = 4;
  localparam int CMS_CTRL_HALVE_BIT = 5;
  localparam int CMS_CTRL_FB_BIT = 6;
  localparam int CMS_CTRL_SRANGE_BIT = 7;
  localparam int CMS_CTRL_LRANGE_BIT = 8;
  localparam int CMS_CTRL_DUTY_BIT = 9;
  localparam int CMS_CTRL_LOCKREQ_BIT = 10;
  // Ratio field positions: half-step divider code, numerator, denominator.
  localparam int CMS_RATIO_DIV_LSB = 0;
  localparam int CMS_RATIO_NUM_LSB = 8;
  localparam int CMS_RATIO_DEN_LSB = 16;
  // Reset values.
  localparam logic [15:0] CMS_JF_RST = 16'hf0f0;
  localparam logic [10:0] CMS_PHASE_RST = 11'h000;
  localparam logic [5:0] CMS_DIV_RST = 6'h04;
  localparam logic [5:0] CMS_NUM_RST = 6'h04;
  localparam logic [5:0] CMS_DEN_RST = 6'h01;
  localparam logic [15:0] CMS_PERIOD_RST = 16'h0000;
  localparam logic CMS_DUTY_RST = 1'b1;
  // Legal limits.
  localparam int CMS_UP_MAX = 255;
  localparam int CMS_CEN_MAX = 255;
  localparam int CMS_DIR_MAX = 1023;
  localparam int CMS_DIV_MIN = 3;
  localparam int CMS_DIV_HALF_MAX = 15;
  localparam int CMS_DIV_MAX = 32;
  localparam int CMS_NUM_MIN = 2;
  localparam int CMS_NUM_MAX = 32;
  localparam int CMS_DEN_MIN = 1;
  localparam int CMS_DEN_MAX = 32;
  localparam int CMS_STEP_DENOM = 256;
  typedef enum logic [2:0] {
    CMS_PS_NONE, CMS_PS_FIXED, CMS_PS_UP, CMS_PS_CENTRED, CMS_PS_DIRECT
  } cms_psmode_t;
endpackage

// [src/cms_settings.sv]
// Clock manager settings register block with APB slave and divider.
`timescale 1ns/100ps
`default_nettype none
module cms_settings
  import cms_pkg::*;
#(
  parameter int JF_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lock_in,
  output logic startup_hold,
  output logic divided_clock_output,
  output logic tap_update,
  output logic config_illegal,
  output logic [11:0] start_offset
);
  if (JF_W != 16) begin : g_jf_check
    $error("jitter filter width must be 16");
  end

  typedef struct packed {
    logic opt_range;
    cms_psmode_t mode;
    logic hold;
    logic halve;
    logic fb_src;
    logic srange_hi;
    logic lrange_hi;
    logic duty_en;
    logic lock_req;
    logic [10:0] phase;
    logic [5:0] div;
    logic [5:0] num;
    logic [5:0] den;
    logic [JF_W-1:0] jf;
    logic [15:0] period;
    logic [1:0] lock_sync;
    logic halve_tgl;
    logic [5:0] div_cnt;
    logic div_out;
    logic [JF_W-1:0] jf_cnt;
    logic tap_up;
    logic illegal;
    logic hold_out;
    logic [11:0] offs;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } cms_state_t;

  cms_state_t s_r;
  cms_state_t s_nxt;

  // Signed offset limit for the chosen mode and optimisation.
  function automatic logic in_range(input cms_psmode_t m,
      input logic [10:0] p, input logic opt_range);
    int v;
    int lim;
    v = $signed(p);
    in_range = 1'b1;
    case (m)
      CMS_PS_UP: begin
        lim = opt_range ? CMS_UP_MAX : CMS_UP_MAX / 2;
        in_range = (v >= 0) && (v <= lim);
      end
      CMS_PS_FIXED, CMS_PS_CENTRED: begin
        lim = opt_range ? CMS_CEN_MAX : CMS_CEN_MAX / 2;
        in_range = (v >= -lim) && (v <= lim);
      end
      CMS_PS_DIRECT: in_range = (v >= 0) && (v <= CMS_DIR_MAX);
      CMS_PS_NONE: in_range = 1'b1;
      default: in_range = 1'b0;
    endcase
  endfunction

  // Divider code is the ratio in half steps.
  function automatic logic ratio_ok(input logic [5:0] d);
    int v;
    v = int'(d);
    ratio_ok = (v >= CMS_DIV_MIN && v <= CMS_DIV_HALF_MAX) ||
               (v >= 16 && v <= CMS_DIV_MAX && v[0] == 1'b0);
  endfunction

  logic acc;
  logic setup;
  assign setup = psel && !penable;
  assign acc = psel && penable && s_r.ready;

  always_comb begin
    s_nxt = s_r;
    s_nxt.lock_sync = {s_r.lock_sync[0], lock_in};
    s_nxt.hold_out = s_r.hold && s_r.lock_req && !s_r.lock_sync[1];
    s_nxt.halve_tgl = s_r.halve ? !s_r.halve_tgl : 1'b1;
    if (s_r.halve_tgl) begin
      if (s_r.div_cnt + 6'h02 >= s_r.div) begin
        s_nxt.div_cnt = s_r.div_cnt + 6'h02 - s_r.div;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 6'h02;
      end
    end
    // High phase is half of ratio for balanced cases.
    if (s_r.div[0] && s_r.lrange_hi) begin
      s_nxt.div_out = s_r.div_cnt < 6'(s_r.div >> 1) - 6'h01;
    end else begin
      s_nxt.div_out = s_r.div_cnt < 6'(s_r.div >> 1);
    end
    // Tap update interval from jitter filter word.
    s_nxt.tap_up = 1'b0;
    if (s_r.jf_cnt >= s_r.jf) begin
      s_nxt.jf_cnt = '0;
      s_nxt.tap_up = 1'b1;
    end else begin
      s_nxt.jf_cnt = s_r.jf_cnt + 1'b1;
    end
    s_nxt.illegal = !in_range(s_r.mode, s_r.phase, s_r.opt_range) ||
        !ratio_ok(s_r.div) ||
        int'(s_r.num) < CMS_NUM_MIN || int'(s_r.num) > CMS_NUM_MAX ||
        int'(s_r.den) < CMS_DEN_MIN || int'(s_r.den) > CMS_DEN_MAX;
    if (s_r.mode == CMS_PS_DIRECT || s_r.mode == CMS_PS_NONE) begin
      s_nxt.offs = 12'h000;
    end else begin
      s_nxt.offs = {s_r.phase[10], s_r.phase};
    end
    // APB slave with no wait cycles; ready in the first access cycle.
    s_nxt.ready = setup;
    s_nxt.err = 1'b0;
    if (setup) begin
      s_nxt.err = paddr[1:0] != 2'b00 || paddr > CMS_PSTEP_OFF;
      s_nxt.rdata = 32'h0000_0000;
      case (paddr)
        CMS_CTRL_OFF: begin
          s_nxt.rdata[CMS_CTRL_OPT_BIT] = s_r.opt_range;
          s_nxt.rdata[CMS_CTRL_MODE_LSB +: 3] = s_r.mode;
          s_nxt.rdata[CMS_CTRL_HOLD_BIT] = s_r.hold;
          s_nxt.rdata[CMS_CTRL_HALVE_BIT] = s_r.halve;
          s_nxt.rdata[CMS_CTRL_FB_BIT] = s_r.fb_src;
          s_nxt.rdata[CMS_CTRL_SRANGE_BIT] = s_r.srange_hi;
          s_nxt.rdata[CMS_CTRL_LRANGE_BIT] = s_r.lrange_hi;
          s_nxt.rdata[CMS_CTRL_DUTY_BIT] = s_r.duty_en;
          s_nxt.rdata[CMS_CTRL_LOCKREQ_BIT] = s_r.lock_req;
        end
        CMS_PHASE_OFF: s_nxt.rdata[10:0] = s_r.phase;
        CMS_RATIO_OFF: s_nxt.rdata = {8'h00, 2'b00, s_r.den, 2'b00,
            s_r.num, 2'b00, s_r.div};
        CMS_JF_OFF: s_nxt.rdata[JF_W-1:0] = s_r.jf;
        CMS_PERIOD_OFF: s_nxt.rdata[15:0] = s_r.period;
        CMS_STATUS_OFF: s_nxt.rdata = {28'h0000000, s_r.hold_out,
            s_r.lock_sync[1], s_r.tap_up, s_r.illegal};
        CMS_PSTEP_OFF: s_nxt.rdata[8:0] = 9'(CMS_STEP_DENOM);
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (acc) begin
      s_nxt.ready = 1'b0;
    end
    if (acc && pwrite && !s_r.err) begin
      case (paddr)
        CMS_CTRL_OFF: begin
          s_nxt.opt_range = pwdata[CMS_CTRL_OPT_BIT];
          // Offset mode; unknown codes fall back to none.
          if (pwdata[CMS_CTRL_MODE_LSB +: 3] <= 3'(CMS_PS_DIRECT)) begin
            s_nxt.mode = cms_psmode_t'(pwdata[CMS_CTRL_MODE_LSB +: 3]);
          end else begin
            s_nxt.mode = CMS_PS_NONE;
          end
          s_nxt.hold = pwdata[CMS_CTRL_HOLD_BIT];
          s_nxt.halve = pwdata[CMS_CTRL_HALVE_BIT];
          s_nxt.fb_src = pwdata[CMS_CTRL_FB_BIT];
          s_nxt.srange_hi = pwdata[CMS_CTRL_SRANGE_BIT];
          s_nxt.lrange_hi = pwdata[CMS_CTRL_LRANGE_BIT];
          s_nxt.duty_en = pwdata[CMS_CTRL_DUTY_BIT];
          s_nxt.lock_req = pwdata[CMS_CTRL_LOCKREQ_BIT];
        end
        CMS_PHASE_OFF: s_nxt.phase = pwdata[10:0];
        CMS_RATIO_OFF: begin
          s_nxt.div = pwdata[CMS_RATIO_DIV_LSB +: 6];
          s_nxt.num = pwdata[CMS_RATIO_NUM_LSB +: 6];
          s_nxt.den = pwdata[CMS_RATIO_DEN_LSB +: 6];
        end
        CMS_JF_OFF: s_nxt.jf = pwdata[JF_W-1:0];
        CMS_PERIOD_OFF: s_nxt.period = pwdata[15:0];
        default: s_nxt.jf = s_r.jf;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.mode <= CMS_PS_NONE;
      s_r.phase <= CMS_PHASE_RST;
      s_r.div <= CMS_DIV_RST;
      s_r.num <= CMS_NUM_RST;
      s_r.den <= CMS_DEN_RST;
      s_r.jf <= CMS_JF_RST;
      s_r.period <= CMS_PERIOD_RST;
      s_r.duty_en <= CMS_DUTY_RST;
      s_r.halve_tgl <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign startup_hold = s_r.hold_out;
  assign divided_clock_output = s_r.div_out;
  assign tap_update = s_r.tap_up;
  assign config_illegal = s_r.illegal;
  assign start_offset = s_r.offs;

  sequence s_tap_gap;
    !tap_update ##1 tap_update;
  endsequence

  a_hold_lock: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.hold && s_r.lock_req && !s_r.lock_sync[1] |=> startup_hold)
    else $error("startup not held without lock");
  a_direct_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_DIRECT |=> start_offset == 12'h000)
    else $error("direct mode start offset not zero");
  a_up_range: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_UP && s_r.opt_range && s_r.phase == 11'h100
    |=> config_illegal)
    else $error("offset 256 not flagged in upward mode");
  a_cen_range: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_CENTRED && s_r.opt_range && s_r.phase == 11'h701
    && ratio_ok(s_r.div) && s_r.num == 6'h04 && s_r.den == 6'h01
    |=> !config_illegal)
    else $error("offset -255 flagged in centred mode");
  a_dir_range: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_DIRECT && s_r.phase[10] |=> config_illegal)
    else $error("negative offset not flagged in direct mode");
  a_speed_narrow: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_UP && !s_r.opt_range && s_r.phase == 11'h080
    |=> config_illegal)
    else $error("speed mode offset not narrowed");
  a_ratio_bad: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.div == 6'h11 |=> config_illegal)
    else $error("ratio 8.5 not flagged");
  a_tap_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    tap_update && s_r.jf == 16'h0001 && !acc |=> s_tap_gap)
    else $error("tap update interval wrong");
  a_ratio_top: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.div == 6'h20 && s_r.num == 6'h20 && s_r.den == 6'h20
    && s_r.mode == CMS_PS_NONE |=> !config_illegal)
    else $error("ratio 16 with 32 over 32 flagged");
  a_num_low: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.num < 6'h02
    |=> config_illegal)
    else $error("numerator below two not flagged");
  a_den_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.den == 6'h00
    |=> config_illegal)
    else $error("denominator zero not flagged");
  a_halver_wait: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.halve && !s_r.halve_tgl
    |=> $stable(s_r.div_cnt))
    else $error("divider counted on a halved-off cycle");
  a_hold_free: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.hold
    |=> !startup_hold)
    else $error("startup held without hold flag");
  a_lock_release: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.lock_sync[1]
    |=> !startup_hold)
    else $error("startup still held after lock");
  a_fixed_low: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_FIXED && s_r.phase == 11'h700
    |=> config_illegal)
    else $error("offset -256 not flagged in fixed mode");
  a_none_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_NONE
    |=> start_offset == 12'h000)
    else $error("start offset not zero without offset mode");
  a_mode_known: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.mode == CMS_PS_NONE || s_r.mode == CMS_PS_FIXED
    || s_r.mode == CMS_PS_UP || s_r.mode == CMS_PS_CENTRED
    || s_r.mode == CMS_PS_DIRECT)
    else $error("offset mode holds an unknown code");
  a_err_zero: assert property (@(posedge clk) disable iff (!rst_n)
    pready && pslverr
    |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_err_pair: assert property (@(posedge clk) disable iff (!rst_n)
    pslverr
    |-> pready)
    else $error("error response without ready");
  a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    pready
    |=> !pready)
    else $error("ready stood longer than one cycle");
  a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready)
    else $error("apb answer not one cycle after setup");
endmodule
`default_nettype wire

// [tb/cms_clock_loads.sv]
// Model of the lock report source beside the settings block.
`timescale 1ns/100ps
`default_nettype none
module cms_clock_loads (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lock_go,
  input wire logic [7:0] lock_dly,
  output logic lock_in
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      lock_in <= 1'b0;
    end else if (!lock_go) begin
      cnt_r <= 8'h00;
      lock_in <= 1'b0;
    end else if (cnt_r >= lock_dly) begin
      lock_in <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the clock manager settings block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cms_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, lock_in, startup_hold, divided_clock_output;
  logic tap_update, config_illegal, lock_go = 0;
  logic [11:0] start_offset;
  int n_fail = 0, n_compared = 0, cyc = 0;
  cms_settings cms_settings_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lock_in(lock_in),
    .startup_hold(startup_hold),
    .divided_clock_output(divided_clock_output), .tap_update(tap_update),
    .config_illegal(config_illegal), .start_offset(start_offset));
  cms_clock_loads cms_clock_loads_i (.clk(clk), .rst_n(rst_n),
    .lock_go(lock_go), .lock_dly(8'h05), .lock_in(lock_in));
  always #25 clk = ~clk;
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask
  task automatic rd(string nm, logic [31:0] a, logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd("ctrl", CMS_CTRL_OFF, 32'h200);
    rd("phase", CMS_PHASE_OFF, 32'h0);
    rd("ratio", CMS_RATIO_OFF, 32'h010404);
    rd("jf", CMS_JF_OFF, 32'hf0f0);
    rd("period", CMS_PERIOD_OFF, 32'h0);
    rd("step", CMS_PSTEP_OFF, 32'h100);
    apb(1'b0, 32'h40, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("Test reset values done");
  endtask
  task automatic cfg(logic [31:0] a, logic [31:0] v, logic ill,
                     logic [11:0] off);
    wr(a, v);
    repeat (3) @(posedge clk);
    chk("illegal", {31'h0, ill}, {31'h0, config_illegal});
    if (!ill) chk("start offset", {20'h0, off}, {20'h0, start_offset});
  endtask
  task automatic t_ranges();
    wr(CMS_CTRL_OFF, 32'h205);
    cfg(CMS_PHASE_OFF, 32'h0ff, 1'b0, 12'h0ff);
    cfg(CMS_PHASE_OFF, 32'h100, 1'b1, 12'h0);
    wr(CMS_CTRL_OFF, 32'h204);
    cfg(CMS_PHASE_OFF, 32'h080, 1'b1, 12'h0);
    wr(CMS_CTRL_OFF, 32'h207);
    cfg(CMS_PHASE_OFF, 32'h701, 1'b0, 12'hf01);
    wr(CMS_CTRL_OFF, 32'h203);
    cfg(CMS_PHASE_OFF, 32'h700, 1'b1, 12'h0);
    wr(CMS_CTRL_OFF, 32'h209);
    cfg(CMS_PHASE_OFF, 32'h3ff, 1'b0, 12'h0);
    cfg(CMS_PHASE_OFF, 32'h400, 1'b1, 12'h0);
    wr(CMS_CTRL_OFF, 32'h200);
    cfg(CMS_PHASE_OFF, 32'h0, 1'b0, 12'h0);
    cfg(CMS_RATIO_OFF, 32'h010402, 1'b1, 12'h0);
    cfg(CMS_RATIO_OFF, 32'h010411, 1'b1, 12'h0);
    cfg(CMS_RATIO_OFF, 32'h010101, 1'b1, 12'h0);
    cfg(CMS_RATIO_OFF, 32'h000404, 1'b1, 12'h0);
    cfg(CMS_RATIO_OFF, 32'h202020, 1'b0, 12'h0);
    $display("Test offset and ratio ranges done");
  endtask
  task automatic t_lock();
    wr(CMS_CTRL_OFF, 32'h610);
    repeat (3) @(posedge clk);
    chk("hold", 32'h1, {31'h0, startup_hold});
    lock_go <= 1'b1;
    repeat (3) @(posedge clk);
    chk("hold slow", 32'h1, {31'h0, startup_hold});
    repeat (12) @(posedge clk);
    chk("released", 32'h0, {31'h0, startup_hold});
    lock_go <= 1'b0;
    wr(CMS_CTRL_OFF, 32'h200);
    $display("Test startup hold done");
  endtask
  task automatic div_chk(logic [31:0] ctrl, logic [31:0] ratio, int edges);
    int ne, nh;
    logic last;
    wr(CMS_CTRL_OFF, ctrl);
    wr(CMS_RATIO_OFF, ratio);
    repeat (40) @(posedge clk);
    ne = 0;
    nh = 0;
    last = divided_clock_output;
    repeat (120) begin
      @(posedge clk);
      if (divided_clock_output === 1'b1) nh++;
      if (divided_clock_output === 1'b1 && last === 1'b0) ne++;
      last = divided_clock_output;
    end
    n_compared++;
    if (ne < edges - 1 || ne > edges + 1 || nh < 59 || nh > 61) begin
      n_fail++;
      $display("BAD divider expected %0d seen %0d high %0d", edges, ne, nh);
    end
  endtask
  task automatic t_div();
    div_chk(32'h200, 32'h010404, 60);
    div_chk(32'h200, 32'h010408, 30);
    div_chk(32'h220, 32'h010404, 30);
    // even ratio keeps balanced high phase for high loop range
    div_chk(32'h300, 32'h010408, 30);
    $display("Test divider done");
  endtask
  task automatic t_tap();
    int n;
    wr(CMS_JF_OFF, 32'h3);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (tap_update === 1'b1) n++;
    end
    chk("tap pulses", 32'd10, n);
    wr(CMS_JF_OFF, 32'h1);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (tap_update === 1'b1) n++;
    end
    chk("tap pulses short", 32'd20, n);
    wr(CMS_JF_OFF, 32'hf0f0);
    $display("Test tap update done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ranges();
    t_lock();
    t_div();
    t_tap();
    final_report();
  end
endmodule
`default_nettype wire
